// ### mks_pkg.sv
// mode key sequencer package: states, key and indicator carriers, timing
// assumes a 20 MHz system clock shared by every user of this package
package mks_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC =
    (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned BEEP_MS       = 100;
  localparam int unsigned BEEP_CYC      = (CLK_HZ / 1000) * BEEP_MS;

  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [1:0] {
    MKS_QUIET   = 2'b00,
    MKS_PERFORM = 2'b01,
    MKS_LOOPING = 2'b10,
    MKS_STOPPED = 2'b11
  } mks_state_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic stop;
    logic cont;
    logic again;
    logic loop;
    logic no;
  } mks_keys_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic resume;
  } mks_engine_cmd_t;

  typedef struct packed {
    logic looping_lamp;
    logic stopped_lamp;
    logic idle_msg;
    logic loop_prompt;
    logic beep;
  } mks_panel_t;

endpackage

// ### mks_flasher.sv
// free running square wave used to flash the panel annunciators
// assumes the enable input is the shared clock enable
`timescale 1ns/10ps
module mks_flasher #(
  parameter int unsigned HALF_CYC = mks_pkg::FLASH_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  output logic      phase
);
  localparam int W = $clog2(HALF_CYC + 1);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      phase   <= 1'b0;
    end else if (ce) begin
      if (cnt_reg >= W'(HALF_CYC - 1)) begin
        cnt_reg <= '0;
        phase   <= ~phase;
      end else begin
        cnt_reg <= cnt_reg + W'(1);
      end
    end
  end
endmodule // mks_flasher

// ### mks_beeper.sv
// one-shot timer that holds the beep output for a fixed length
// assumes a trigger is a one-cycle pulse; a new trigger restarts it
`timescale 1ns/10ps
module mks_beeper #(
  parameter int unsigned LEN_CYC = mks_pkg::BEEP_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic trig,
  output logic      beep
);
  localparam int W = $clog2(LEN_CYC + 1);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      beep    <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        cnt_reg <= W'(LEN_CYC - 1);
        beep    <= 1'b1;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - W'(1);
      end else begin
        beep    <= 1'b0;
      end
    end
  end
endmodule // mks_beeper

// ### mks_sequencer.sv
// mode key sequencer: reacts to stop, continue, again and loop keys
// while a selected function or built-in test runs on an engine.
// assumes keys arrive as single-cycle pulses synchronous to CLK and the
// engine reports done or error with one-cycle pulses.
`timescale 1ns/10ps

// ************************************************************
// sequencer top
// ************************************************************
// Overview of operation
// - reset gives quiescent; selecting a function starts performing.
// - error-free completion returns to quiescent by itself.
// - stop while quiescent keeps state, only restores idle message.
// - stop during performing aborts it and goes quiescent.
// - again after completion performs the same function once more.
// - loop after completion enters looping, flashing lamp, endless reruns.
// - stop while looping enters stopped with flashing stopped lamp.
// - stopped state starts nothing and waits for a key.
// - loop while stopped resumes looping, lamps swap flashing.
// - stop while stopped returns to quiescent with idle message.
// - again during performing restarts the function from the beginning.
// - loop during performing goes straight to looping.
// - again while looping ends looping and performs once more.
// - again while stopped enters looping.
// - continue without pending error only beeps.
// - same transitions for every function and built-in test.
// - test error halts, stopped lamp lit, loop prompt shown.
// - no or continue after error stop resumes the halted test.
module mks_sequencer #(
  parameter int unsigned FLASH_HALF = mks_pkg::FLASH_HALF_CYC,
  parameter int unsigned BEEP_LEN   = mks_pkg::BEEP_CYC
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  SELECT,
  input  wire mks_pkg::mks_keys_t    KEYS,
  input  wire logic                  DONE,
  input  wire logic                  ERROR,
  output mks_pkg::mks_engine_cmd_t   CMD,
  output mks_pkg::mks_panel_t        PANEL,
  output mks_pkg::mks_state_t        STATE
);

  // ************************************************************
  // state
  // ************************************************************
  mks_pkg::mks_state_t state_reg;
  mks_pkg::mks_state_t state_next;
  logic                ran_reg;
  logic                ran_next;
  logic                err_reg;
  logic                err_next;
  logic                idle_reg;
  logic                idle_next;
  logic                start_next;
  logic                abort_next;
  logic                resume_next;
  logic                beep_trig;
  logic                flash;
  logic                beep_w;
  logic                loop_lamp_reg;
  logic                stop_lamp_reg;
  mks_pkg::mks_engine_cmd_t cmd_reg;

  // ************************************************************
  // key decode
  // ************************************************************
  // keys are one-hot per cycle, so plain priority order is harmless
  always_comb begin
    state_next  = state_reg;
    ran_next    = ran_reg;
    err_next    = err_reg;
    idle_next   = idle_reg;
    start_next  = 1'b0;
    abort_next  = 1'b0;
    resume_next = 1'b0;
    beep_trig   = 1'b0;
    case (state_reg)
      mks_pkg::MKS_QUIET: begin
        if (SELECT) begin
          state_next = mks_pkg::MKS_PERFORM;
          start_next = 1'b1;
          ran_next   = 1'b1;
          idle_next  = 1'b0;
        end else if (KEYS.stop) begin
          idle_next = 1'b1;
        end else if (KEYS.again && ran_reg) begin
          state_next = mks_pkg::MKS_PERFORM;
          start_next = 1'b1;
          idle_next  = 1'b0;
        end else if (KEYS.loop && ran_reg) begin
          state_next = mks_pkg::MKS_LOOPING;
          start_next = 1'b1;
          idle_next  = 1'b0;
        end else if (KEYS.cont) begin
          beep_trig = 1'b1;
        end
      end
      mks_pkg::MKS_PERFORM: begin
        if (KEYS.stop) begin
          state_next = mks_pkg::MKS_QUIET;
          abort_next = 1'b1;
        end else if (KEYS.again) begin
          abort_next = 1'b1;
          start_next = 1'b1;
        end else if (KEYS.loop) begin
          state_next = mks_pkg::MKS_LOOPING;
        end else if (KEYS.cont) begin
          beep_trig = 1'b1;
        end else if (ERROR) begin
          state_next = mks_pkg::MKS_STOPPED;
          err_next   = 1'b1;
          beep_trig  = 1'b1;
        end else if (DONE) begin
          state_next = mks_pkg::MKS_QUIET;
        end
      end
      mks_pkg::MKS_LOOPING: begin
        if (KEYS.stop) begin
          state_next = mks_pkg::MKS_STOPPED;
          abort_next = 1'b1;
        end else if (KEYS.again) begin
          state_next = mks_pkg::MKS_PERFORM;
          abort_next = 1'b1;
          start_next = 1'b1;
        end else if (KEYS.cont) begin
          beep_trig = 1'b1;
        end else if (ERROR) begin
          state_next = mks_pkg::MKS_STOPPED;
          err_next   = 1'b1;
          beep_trig  = 1'b1;
        end else if (DONE) begin
          start_next = 1'b1;
        end
      end
      mks_pkg::MKS_STOPPED: begin
        // nothing is started here without a key
        if (KEYS.stop) begin
          state_next = mks_pkg::MKS_QUIET;
          idle_next  = 1'b1;
          err_next   = 1'b0;
          abort_next = err_reg;
        end else if (KEYS.loop || KEYS.again) begin
          state_next = mks_pkg::MKS_LOOPING;
          err_next   = 1'b0;
          abort_next = err_reg;
          start_next = 1'b1;
        end else if (err_reg && (KEYS.no || KEYS.cont)) begin
          state_next  = mks_pkg::MKS_PERFORM;
          err_next    = 1'b0;
          resume_next = 1'b1;
        end else if (KEYS.cont) begin
          beep_trig = 1'b1;
        end
      end
      default: begin
        state_next = mks_pkg::MKS_QUIET;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= mks_pkg::MKS_QUIET;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // history flags
  // ************************************************************
  // again and loop need a function to repeat, so they wait for a first run
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ran_reg <= 1'b0;
    end else if (CE) begin
      ran_reg <= ran_next;
    end
  end

  // set by an engine error, cleared by whatever key leaves the error stop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      err_reg <= 1'b0;
    end else if (CE) begin
      err_reg <= err_next;
    end
  end

  // the idle message is up out of reset, as after a stop in quiescence
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      idle_reg <= 1'b1;
    end else if (CE) begin
      idle_reg <= idle_next;
    end
  end

  // ************************************************************
  // engine commands
  // ************************************************************
  // a low enable holds a pulse, so the engine must share the enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_reg <= '0;
    end else if (CE) begin
      cmd_reg.start  <= start_next;
      cmd_reg.abort  <= abort_next;
      cmd_reg.resume <= resume_next;
    end
  end

  // ************************************************************
  // panel helpers
  // ************************************************************
  mks_flasher #(
    .HALF_CYC (FLASH_HALF)
  ) u_flash (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .phase (flash)
  );

  mks_beeper #(
    .LEN_CYC (BEEP_LEN)
  ) u_beep (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .trig (beep_trig),
    .beep (beep_w)
  );

  // ************************************************************
  // indicators
  // ************************************************************
  // lamps follow the next state so they change on the same edge as STATE
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      loop_lamp_reg <= 1'b0;
    end else if (CE) begin
      loop_lamp_reg <=
        (state_next == mks_pkg::MKS_LOOPING) && flash;
    end
  end

  // an error stop shows a steady lamp; an operator stop flashes it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stop_lamp_reg <= 1'b0;
    end else if (CE) begin
      stop_lamp_reg <= (state_next == mks_pkg::MKS_STOPPED) &&
        (err_next || flash);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    PANEL.looping_lamp = loop_lamp_reg;
    PANEL.stopped_lamp = stop_lamp_reg;
    PANEL.idle_msg     = idle_reg;
    PANEL.loop_prompt  = err_reg;
    PANEL.beep         = beep_w;
  end

  assign CMD   = cmd_reg;
  assign STATE = state_reg;

endmodule // mks_sequencer

// ### mks_seq_chk.sv
// port assertions for the mode key sequencer, bound to its top module
// assumes keys and engine reports arrive as one-cycle pulses
`timescale 1ns/10ps
module mks_seq_chk #(
  parameter int unsigned FLASH_HALF = 4,
  parameter int unsigned BEEP_LEN   = 3
) (
  input wire logic                     CLK,
  input wire logic                     RST,
  input wire logic                     CE,
  input wire logic                     SELECT,
  input wire mks_pkg::mks_keys_t       KEYS,
  input wire logic                     DONE,
  input wire logic                     ERROR,
  input wire mks_pkg::mks_engine_cmd_t CMD,
  input wire mks_pkg::mks_panel_t      PANEL,
  input wire mks_pkg::mks_state_t      STATE
);
  localparam mks_pkg::mks_state_t sq = mks_pkg::MKS_QUIET;
  localparam mks_pkg::mks_state_t sp = mks_pkg::MKS_PERFORM;
  localparam mks_pkg::mks_state_t sl = mks_pkg::MKS_LOOPING;
  localparam mks_pkg::mks_state_t ss = mks_pkg::MKS_STOPPED;
  // ce folded in so a frozen cycle never arms a check
  wire q = CE && STATE == sq;
  wire p = CE && STATE == sp;
  wire l = CE && STATE == sl;
  wire s = CE && STATE == ss;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_SELECT:
    assert property (q && SELECT |=> STATE == sp && CMD.start)
    else $error("select did not start");
  AST_DONE:
    assert property (p && DONE && KEYS == '0 |=> STATE == sq)
    else $error("no return to quiet");
  AST_STOP_P:
    assert property (p && KEYS.stop |=> STATE == sq && CMD.abort)
    else $error("stop did not abort");
  AST_STOP_L:
    assert property (l && KEYS.stop |=> STATE == ss)
    else $error("stop in loop not stopped");
  AST_IDLE_S:
    assert property (s && KEYS == '0 |=> STATE == ss && !CMD.start)
    else $error("stopped state acted alone");
  AST_LOOP_S:
    assert property (s && KEYS.loop |=> STATE == sl && !PANEL.stopped_lamp)
    else $error("loop did not resume");
  AST_STOP_S:
    assert property (s && KEYS.stop |=> STATE == sq && PANEL.idle_msg)
    else $error("stop did not reach quiet");
  AST_AGAIN_P:
    assert property (p && KEYS.again |=> CMD.start && CMD.abort)
    else $error("again did not restart");
  AST_LOOP_P:
    assert property (p && KEYS.loop |=> STATE == sl && !CMD.start)
    else $error("loop did not go straight to looping");
  AST_RESUME:
    assert property (s && PANEL.loop_prompt && KEYS.no
                     |=> STATE == sp && CMD.resume)
    else $error("no did not resume the halted test");
  AST_AGAIN_L:
    assert property (l && KEYS.again |=> STATE == sp)
    else $error("again did not end loop");
  AST_AGAIN_S:
    assert property (s && KEYS.again |=> STATE == sl)
    else $error("again did not loop");
  AST_CONT:
    assert property (q && KEYS.cont |=> STATE == sq ##[0:3] PANEL.beep)
    else $error("continue did not beep");
  AST_ERROR:
    assert property (p && ERROR && KEYS == '0
                     |=> STATE == ss && PANEL.loop_prompt)
    else $error("error did not stop");

  cover property (l && KEYS.stop);
  cover property (p && ERROR);
  cover property (s && KEYS.loop);
endmodule // mks_seq_chk

bind mks_sequencer mks_seq_chk #(
  .FLASH_HALF(FLASH_HALF), .BEEP_LEN(BEEP_LEN)) i_mks_seq_chk (
  .CLK(CLK), .RST(RST), .CE(CE), .SELECT(SELECT), .KEYS(KEYS),
  .DONE(DONE), .ERROR(ERROR), .CMD(CMD), .PANEL(PANEL), .STATE(STATE));

// ### mks_engine_model.sv
// engine stand-in: answers start or resume with done after dly cycles
// assumes dly is nonzero; fail halts a running job with an error pulse
`timescale 1ns/10ps
module mks_engine_model (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire mks_pkg::mks_engine_cmd_t cmd,
  input  wire logic [7:0]               dly,
  input  wire logic                     fail,
  output logic                          done,
  output logic                          error
);
  logic [7:0] cnt_reg;

  // start wins over abort, so a restart reloads the full length
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      done    <= 1'b0;
      error   <= 1'b0;
    end else begin
      done  <= 1'b0;
      error <= 1'b0;
      if (cmd.start || cmd.resume) begin
        cnt_reg <= dly;
      end else if (cmd.abort || fail) begin
        cnt_reg <= 8'h00;
        error   <= fail && cnt_reg != 8'h00;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
        done    <= cnt_reg == 8'h01;
      end
    end
  end
endmodule // mks_engine_model

// ### mks_sequencer_tb_top.sv
// self-checking bench for the mode key sequencer
// assumes the engine model answers start and resume after dly cycles
`timescale 1ns/10ps
module mks_sequencer_tb_top;
  logic                     clk;
  logic                     rst;
  logic                     ce;
  logic                     sel;
  mks_pkg::mks_keys_t       keys;
  logic                     done;
  logic                     error;
  mks_pkg::mks_engine_cmd_t cmd;
  mks_pkg::mks_panel_t      panel;
  mks_pkg::mks_state_t      state;
  logic [7:0]               dly;
  logic                     fail;
  int                       n_mismatch;
  int                       check_count;
  localparam logic [4:0] k_stop = 5'h10, k_cont = 5'h08;
  localparam logic [4:0] k_again = 5'h04, k_loop = 5'h02, k_no = 5'h01;

  mks_sequencer #(.FLASH_HALF(4), .BEEP_LEN(3)) i_mks_sequencer (
    .CLK(clk), .RST(rst), .CE(ce), .SELECT(sel), .KEYS(keys),
    .DONE(done), .ERROR(error), .CMD(cmd), .PANEL(panel), .STATE(state));
  mks_engine_model i_mks_engine_model (.clk(clk), .rst(rst), .cmd(cmd),
    .dly(dly), .fail(fail), .done(done), .error(error));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cmp(input string n, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", n, e, g);
    end
  endtask

  // key or select held for exactly one sampled edge
  task automatic go(input logic [4:0] k, input logic s);
    @(posedge clk);
    keys <= k;
    sel  <= s;
    @(posedge clk);
    keys <= 5'h00;
    sel  <= 1'b0;
    #1;
  endtask

  task automatic wst(input mks_pkg::mks_state_t s);
    for (int i = 0; i < 80 && state !== s; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("state", s, state);
  endtask

  task automatic wbit(input int b, input string n);
    for (int i = 0; i < 20 && panel[b] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp(n, 2'h1, {1'b0, panel[b]});
  endtask

  task automatic starts(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (cmd.start === 1'b1) c++;
    end
  endtask

  task automatic t_plain;
    wst(mks_pkg::MKS_QUIET);
    cmp("idle", 2'h1, {1'b0, panel.idle_msg});
    go(5'h00, 1'b1);
    cmp("state", mks_pkg::MKS_PERFORM, state);
    cmp("start", 2'h1, {1'b0, cmd.start});
    cmp("idle", 2'h0, {1'b0, panel.idle_msg});
    wst(mks_pkg::MKS_QUIET);
    go(k_stop, 1'b0);
    cmp("state", mks_pkg::MKS_QUIET, state);
    cmp("idle", 2'h1, {1'b0, panel.idle_msg});
    go(k_cont, 1'b0);
    wbit(0, "beep");
    cmp("state", mks_pkg::MKS_QUIET, state);
  endtask

  // a frozen enable must swallow a key that would otherwise start a run
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    go(k_again, 1'b0);
    cmp("frozen start", 2'h0, {1'b0, cmd.start});
    cmp("state", mks_pkg::MKS_QUIET, state);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic t_again;
    go(k_again, 1'b0);
    cmp("start", 2'h1, {1'b0, cmd.start});
    go(k_again, 1'b0);
    cmp("restart", 2'h3, {cmd.abort, cmd.start});
    go(k_stop, 1'b0);
    cmp("abort", 2'h1, {1'b0, cmd.abort});
    cmp("state", mks_pkg::MKS_QUIET, state);
  endtask

  task automatic t_loop;
    int c;
    go(5'h00, 1'b1);
    go(k_loop, 1'b0);
    cmp("state", mks_pkg::MKS_LOOPING, state);
    wbit(4, "loop lamp");
    starts(40, c);
    cmp("reruns", 2'h1, {1'b0, c > 1});
    go(k_stop, 1'b0);
    wbit(3, "stop lamp");
    starts(20, c);
    cmp("idle starts", 2'h0, {1'b0, c != 0});
    go(k_loop, 1'b0);
    cmp("lamps", 2'h2, {state == mks_pkg::MKS_LOOPING,
                        panel.stopped_lamp});
    go(k_stop, 1'b0);
    go(k_again, 1'b0);
    cmp("state", mks_pkg::MKS_LOOPING, state);
    go(k_again, 1'b0);
    cmp("state", mks_pkg::MKS_PERFORM, state);
    wst(mks_pkg::MKS_QUIET);
    go(k_loop, 1'b0);
    cmp("state", mks_pkg::MKS_LOOPING, state);
    go(k_stop, 1'b0);
    go(k_stop, 1'b0);
    cmp("idle", 2'h3, {state == mks_pkg::MKS_QUIET,
                       panel.idle_msg});
  endtask

  task automatic t_err(input logic [4:0] k);
    go(5'h00, 1'b1);
    repeat (2) @(posedge clk);
    fail <= 1'b1;
    @(posedge clk);
    fail <= 1'b0;
    wst(mks_pkg::MKS_STOPPED);
    cmp("prompt", 2'h3, {panel.loop_prompt, panel.stopped_lamp});
    go(k, 1'b0);
    cmp("resume", 2'h3, {state == mks_pkg::MKS_PERFORM,
                         cmd.resume});
    wst(mks_pkg::MKS_QUIET);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sel = 1'b0;
    keys = 5'h00;
    dly = 8'h08;
    fail = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_plain;
    t_freeze;
    t_again;
    dly <= 8'h03;
    t_loop;
    dly <= 8'h06;
    t_err(k_no);
    t_err(k_cont);
    complete_run;
  end
endmodule // mks_sequencer_tb_top
